// ---- adp_core.sv ----
// Purpose: digital post processing, power control and output interface
// Assumes: sample_clk and converter words come from outside pclk domain
// Notes: APB slave answers with one access cycle, no wait states
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module adp_core #(
   parameter int WAKE_GLOBAL_CYC = adp_pkg::WAKE_GLOBAL_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sample_clk,
   input  wire logic [13:0] conv_a,
   input  wire logic [13:0] conv_b,
   input  wire logic [1:0]  conv_ovr_a,
   input  wire logic [1:0]  conv_ovr_b,
   input  wire logic        power_ctrl_pin_1,
   input  wire logic        power_ctrl_pin_2,
   input  wire logic        power_ctrl_pin_3,
   input  wire logic        format_select_pin,
   input  wire logic        serial_select_pin,
   output logic [13:0]      bus_a_data,
   output logic             bus_a_oe,
   output logic [13:0]      bus_b_data,
   output logic             bus_b_oe,
   output logic             output_clock_pos,
   output logic             output_clock_oe,
   output logic             data_valid_a,
   output logic             data_valid_b,
   output logic             low_power_mode
);
   localparam int NCH = 2;

   adp_pkg::adp_samp_t samp_s1_reg;
   adp_pkg::adp_samp_t samp_s2_reg;
   adp_pkg::adp_pins_t pins_s1_reg;
   adp_pkg::adp_pins_t pins_s2_reg;
   logic               sclk_d_reg;
   logic               rise_en;
   logic               fall_en;

   logic [adp_pkg::CTRL_W-1:0] ctrl_reg;
   logic [3:0]                 gain_reg;
   logic [3:0]                 tc_reg;
   logic [31:0]                rdata_next;
   logic                       addr_ok;

   adp_pkg::adp_pwr_t  pwr_mode;
   logic               global_pd;
   logic [12:0]        wake_cnt_reg;
   logic [11:0]        stby_cnt_reg [NCH];
   logic [NCH-1:0]     ch_off;
   logic [NCH-1:0]     ch_valid;
   logic [6:0]         gap_cnt_reg;
   logic               low_clk_reg;

   logic               dig_en;
   logic               fmt_ob;
   logic               if_cmos;
   logic               mux_mode;

   adp_pkg::adp_samp_t pipe_reg [adp_pkg::RAW_LAT];
   logic signed [13:0] raw_tap   [NCH];
   logic [1:0]         ovr_tap   [NCH];
   logic signed [13:0] gain_reg_s [NCH];
   logic signed [13:0] ofs_reg_s  [NCH];
   logic signed [13:0] fin_reg_s  [NCH];
   logic [1:0]         ovr1_reg  [NCH];
   logic [1:0]         ovr2_reg  [NCH];
   logic [1:0]         ovr3_reg  [NCH];
   logic signed [13:0] est       [NCH];
   logic [13:0]        word_next [NCH];
   logic [13:0]        word_reg  [NCH];

   function automatic logic signed [13:0] sat14(input logic signed [17:0] v);
      if (v > 18'(adp_pkg::CODE_POS)) begin
         return adp_pkg::CODE_POS;
      end else if (v < 18'(adp_pkg::CODE_NEG)) begin
         return adp_pkg::CODE_NEG;
      end else begin
         return v[13:0];
      end
   endfunction

   function automatic logic [6:0] pick_bits(input logic [13:0] w, input logic odd);
      logic [6:0] r;
      r = '0;
      for (int i = 0; i < 7; i++) begin
         r[i] = w[2 * i + (odd ? 1 : 0)];
      end
      return r;
   endfunction

   // Converter words are held a full sample period, so two flops are enough
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samp_s1_reg <= '0;
         samp_s2_reg <= '0;
         pins_s1_reg <= '0;
         pins_s2_reg <= '0;
         sclk_d_reg  <= 1'b0;
      end else begin
         samp_s1_reg <= {conv_a, conv_b, conv_ovr_a, conv_ovr_b};
         samp_s2_reg <= samp_s1_reg;
         pins_s1_reg <= {sample_clk, power_ctrl_pin_1, power_ctrl_pin_2, power_ctrl_pin_3,
                         format_select_pin, serial_select_pin};
         pins_s2_reg <= pins_s1_reg;
         sclk_d_reg  <= pins_s2_reg.sclk;
      end
   end

   assign rise_en = pins_s2_reg.sclk && !sclk_d_reg;
   assign fall_en = !pins_s2_reg.sclk && sclk_d_reg;

   // APB slave: pready rises in the access cycle, data latched at setup
   always_comb begin
      addr_ok = 1'b1;
      rdata_next = '0;
      case (paddr)
         adp_pkg::OFF_CTRL:   rdata_next = 32'(ctrl_reg);
         adp_pkg::OFF_GAIN:   rdata_next = {28'h0, gain_reg};
         adp_pkg::OFF_TC:     rdata_next = {28'h0, tc_reg};
         adp_pkg::OFF_STATUS: rdata_next = {25'h0, fmt_ob, if_cmos, ch_valid, low_clk_reg,
                                            2'(pwr_mode)};
         adp_pkg::OFF_OFS_A:  rdata_next = 32'(est[0]);
         adp_pkg::OFF_OFS_B:  rdata_next = 32'(est[1]);
         default:             addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         prdata  <= (psel && !penable && !pwrite) ? rdata_next : 32'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= adp_pkg::CTRL_RST;
         gain_reg <= adp_pkg::GAIN_RST;
         tc_reg   <= adp_pkg::TC_RST;
      end else if (psel && penable && pready && pwrite) begin
         case (paddr)
            adp_pkg::OFF_CTRL: ctrl_reg <= pwdata[adp_pkg::CTRL_W-1:0];
            adp_pkg::OFF_GAIN: gain_reg <= pwdata[3:0];
            adp_pkg::OFF_TC:   tc_reg <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   // Pin configuration mode relies on presetn held high by the board
   always_comb begin
      dig_en  = ctrl_reg[adp_pkg::B_DIG_EN];
      fmt_ob  = ctrl_reg[adp_pkg::B_PIN_CFG] ? pins_s2_reg.fmt
                                             : ctrl_reg[adp_pkg::B_FMT_OB];
      if_cmos = ctrl_reg[adp_pkg::B_PIN_CFG] ? pins_s2_reg.ser
                                             : ctrl_reg[adp_pkg::B_IF_CMOS];
      case ({pins_s2_reg.p1, pins_s2_reg.p2, pins_s2_reg.p3})
         3'b100:  pwr_mode = adp_pkg::PWR_GLOBAL;
         3'b101:  pwr_mode = adp_pkg::PWR_CHA_OFF;
         3'b111:  pwr_mode = adp_pkg::PWR_MUX;
         default: pwr_mode = adp_pkg::PWR_NORMAL;
      endcase
      global_pd = (pwr_mode == adp_pkg::PWR_GLOBAL) || ctrl_reg[adp_pkg::B_SLEEP];
      mux_mode  = (pwr_mode == adp_pkg::PWR_MUX);
      ch_off[0] = (pwr_mode == adp_pkg::PWR_CHA_OFF) || ctrl_reg[adp_pkg::B_STBY_A];
      ch_off[1] = ctrl_reg[adp_pkg::B_STBY_B];
   end

   // Wake counters reload while asleep and run down after wake-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_cnt_reg <= '0;
      end else if (global_pd) begin
         wake_cnt_reg <= 13'(WAKE_GLOBAL_CYC);
      end else if (wake_cnt_reg != '0) begin
         wake_cnt_reg <= wake_cnt_reg - 13'h1;
      end
   end

   // Gaps longer than 1 us between sample edges mean the clock has slowed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_cnt_reg <= '0;
         low_clk_reg <= 1'b0;
      end else if (rise_en) begin
         gap_cnt_reg <= '0;
         low_clk_reg <= 1'b0;
      end else if (gap_cnt_reg >= 7'(adp_pkg::LOWCLK_CYC)) begin
         low_clk_reg <= 1'b1;
      end else begin
         gap_cnt_reg <= gap_cnt_reg + 7'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < adp_pkg::RAW_LAT; i++) begin
            pipe_reg[i] <= '0;
         end
      end else if (rise_en) begin
         pipe_reg[0] <= samp_s2_reg;
         for (int i = 1; i < adp_pkg::RAW_LAT; i++) begin
            pipe_reg[i] <= pipe_reg[i-1];
         end
      end
   end

   assign raw_tap[0] = pipe_reg[adp_pkg::RAW_LAT-1].a;
   assign raw_tap[1] = pipe_reg[adp_pkg::RAW_LAT-1].b;
   assign ovr_tap[0] = pipe_reg[adp_pkg::RAW_LAT-1].ovr_a;
   assign ovr_tap[1] = pipe_reg[adp_pkg::RAW_LAT-1].ovr_b;

   // Stage order per channel: gain, offset, clamp, then format
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic signed [29:0] prod;
      logic [3:0]         g_eff;
      logic signed [13:0] fin_code;

      assign g_eff = (gain_reg > adp_pkg::GAIN_MAX_CODE) ? adp_pkg::GAIN_MAX_CODE : gain_reg;
      assign prod  = raw_tap[c] * $signed(adp_pkg::GAIN_COEF[g_eff]);

      adp_offset_est u_est (
         .pclk      (pclk),
         .presetn   (presetn),
         .sample_en (rise_en),
         .enable    (dig_en && ctrl_reg[adp_pkg::B_OFS_EN]),
         .track     (ctrl_reg[adp_pkg::B_OFS_TRK]),
         .tc_sel    (tc_reg),
         .din       (gain_reg_s[c]),
         .est       (est[c])
      );

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            gain_reg_s[c] <= '0;
            ofs_reg_s[c]  <= '0;
            fin_reg_s[c]  <= '0;
            ovr1_reg[c]   <= '0;
            ovr2_reg[c]   <= '0;
            ovr3_reg[c]   <= '0;
         end else if (rise_en) begin
            gain_reg_s[c] <= sat14(18'(prod >>> adp_pkg::GAIN_FRAC));
            ofs_reg_s[c]  <= (ctrl_reg[adp_pkg::B_OFS_EN])
                             ? sat14(18'(gain_reg_s[c]) - 18'(est[c]))
                             : gain_reg_s[c];
            fin_reg_s[c]  <= ofs_reg_s[c];
            ovr1_reg[c]   <= ovr_tap[c];
            ovr2_reg[c]   <= ovr1_reg[c];
            ovr3_reg[c]   <= ovr2_reg[c];
         end
      end

      always_comb begin
         logic [1:0] ov;
         logic signed [13:0] v;
         ov = dig_en ? ovr3_reg[c] : ovr_tap[c];
         v  = dig_en ? fin_reg_s[c] : raw_tap[c];
         if (ov[1]) begin
            fin_code = adp_pkg::CODE_POS;
         end else if (ov[0]) begin
            fin_code = adp_pkg::CODE_NEG;
         end else begin
            fin_code = v;
         end
         // Offset binary is the twos complement code with its sign inverted
         if (!ch_valid[c]) begin
            word_next[c] = '0;
         end else if (fmt_ob) begin
            word_next[c] = {~fin_code[13], fin_code[12:0]};
         end else begin
            word_next[c] = fin_code;
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            stby_cnt_reg[c] <= '0;
         end else if (ch_off[c] || global_pd) begin
            stby_cnt_reg[c] <= 12'(adp_pkg::WAKE_STBY_CYC);
         end else if (stby_cnt_reg[c] != '0) begin
            stby_cnt_reg[c] <= stby_cnt_reg[c] - 12'h1;
         end
      end

      assign ch_valid[c] = !global_pd && !ch_off[c] && (wake_cnt_reg == '0)
                           && (stby_cnt_reg[c] == '0) && !low_clk_reg;

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            word_reg[c] <= '0;
         end else if (rise_en) begin
            word_reg[c] <= word_next[c];
         end
      end
   end

   // Output pins: clock follows the sample clock, data moves with its edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_a_data       <= '0;
         bus_b_data       <= '0;
         output_clock_pos <= 1'b0;
      end else if (rise_en) begin
         output_clock_pos <= 1'b1;
         if (mux_mode) begin
            bus_b_data <= word_next[0];
         end else if (if_cmos) begin
            bus_a_data <= word_next[0];
            bus_b_data <= word_next[1];
         end else begin
            bus_a_data <= {7'h0, pick_bits(word_next[0], 1'b0)};
            bus_b_data <= {7'h0, pick_bits(word_next[1], 1'b0)};
         end
      end else if (fall_en) begin
         output_clock_pos <= 1'b0;
         if (mux_mode) begin
            bus_b_data <= word_reg[1];
         end else if (!if_cmos) begin
            bus_a_data <= {7'h0, pick_bits(word_reg[0], 1'b1)};
            bus_b_data <= {7'h0, pick_bits(word_reg[1], 1'b1)};
         end
      end
   end

   // Mux mode is only sound below 80 MSPS; nothing here enforces that
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_a_oe        <= 1'b0;
         bus_b_oe        <= 1'b0;
         output_clock_oe <= 1'b0;
         data_valid_a    <= 1'b0;
         data_valid_b    <= 1'b0;
         low_power_mode  <= 1'b0;
      end else begin
         bus_a_oe        <= !global_pd && !mux_mode;
         bus_b_oe        <= !global_pd;
         output_clock_oe <= !global_pd;
         data_valid_a    <= ch_valid[0];
         data_valid_b    <= ch_valid[1];
         low_power_mode  <= low_clk_reg || global_pd;
      end
   end
endmodule

// ---- adp_pkg.sv ----
// Purpose: shared constants and types of the converter digital back end
// Assumes: pclk at 50 MHz; converter samples arrive as twos complement
// Notes: offsets are APB byte addresses
package adp_pkg;
   localparam int          CLK_PERIOD_NS   = 20;
   localparam int          T_WAKE_GLOBAL_NS = 100000;
   localparam int          T_WAKE_STBY_NS  = 50000;
   localparam int          T_LOWCLK_NS     = 1000;
   localparam int          WAKE_GLOBAL_CYC = T_WAKE_GLOBAL_NS / CLK_PERIOD_NS;
   localparam int          WAKE_STBY_CYC   = T_WAKE_STBY_NS / CLK_PERIOD_NS;
   localparam int          LOWCLK_CYC      = T_LOWCLK_NS / CLK_PERIOD_NS;
   localparam int          RAW_LAT         = 16;
   localparam int          DIG_EXTRA       = 3;
   localparam int          TC_BASE_SHIFT   = 20;
   localparam logic [3:0]  TC_MAX_CODE     = 4'hb;
   localparam logic signed [13:0] OFS_LIMIT = 14'sh0052;
   localparam logic [3:0]  GAIN_MAX_CODE   = 4'hc;
   localparam int          GAIN_FRAC       = 14;
   localparam logic [11:0] OFF_CTRL   = 12'h000;
   localparam logic [11:0] OFF_GAIN   = 12'h004;
   localparam logic [11:0] OFF_TC     = 12'h008;
   localparam logic [11:0] OFF_STATUS = 12'h00c;
   localparam logic [11:0] OFF_OFS_A  = 12'h010;
   localparam logic [11:0] OFF_OFS_B  = 12'h014;
   localparam int          B_DIG_EN   = 0;
   localparam int          B_OFS_EN   = 1;
   localparam int          B_OFS_TRK  = 2;
   localparam int          B_SLEEP    = 3;
   localparam int          B_FMT_OB   = 4;
   localparam int          B_IF_CMOS  = 5;
   localparam int          B_PIN_CFG  = 6;
   localparam int          B_STBY_A   = 7;
   localparam int          B_STBY_B   = 8;
   localparam int          CTRL_W     = 9;
   localparam logic [8:0]  CTRL_RST   = 9'h004;
   localparam logic [3:0]  GAIN_RST   = 4'h0;
   localparam logic [3:0]  TC_RST     = 4'h0;
   localparam logic signed [13:0] CODE_POS = 14'sh1fff;
   localparam logic signed [13:0] CODE_NEG = 14'sh2000;
   // Q2.14 factors for 10^(g/40), g = half-dB code
   localparam logic [15:0] GAIN_COEF [13] = '{16'h4000, 16'h43cb, 16'h47cf, 16'h4c10,
      16'h5092, 16'h5558, 16'h5a67, 16'h5fc2, 16'h656e, 16'h6b71, 16'h71cf, 16'h788e,
      16'h7fb2};

   typedef enum {PWR_NORMAL, PWR_GLOBAL, PWR_CHA_OFF, PWR_MUX} adp_pwr_t;

   typedef struct packed {
      logic signed [13:0] a;
      logic signed [13:0] b;
      logic [1:0]         ovr_a;
      logic [1:0]         ovr_b;
   } adp_samp_t;

   typedef struct packed {
      logic sclk;
      logic p1;
      logic p2;
      logic p3;
      logic fmt;
      logic ser;
   } adp_pins_t;
endpackage

// ---- adp_offset_est.sv ----
// Purpose: per-channel dc offset estimator, first-order accumulator
// Assumes: sample_en is a one-cycle pulse per sample
// Notes: estimate is limited to about 10 mV of full scale
`timescale 1ns/1ps
module adp_offset_est (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               sample_en,
   input  wire logic               enable,
   input  wire logic               track,
   input  wire logic [3:0]         tc_sel,
   input  wire logic signed [13:0] din,
   output logic signed [13:0]      est
);
   logic signed [47:0] acc_reg;
   logic signed [47:0] acc_next;
   logic signed [47:0] est_full;
   logic [5:0]         shift;
   logic [3:0]         tc_eff;

   always_comb begin
      // Reserved codes stay at the longest time constant
      tc_eff = (tc_sel > adp_pkg::TC_MAX_CODE) ? adp_pkg::TC_MAX_CODE : tc_sel;
      shift = 6'(adp_pkg::TC_BASE_SHIFT) + {2'h0, tc_eff};
      est_full = acc_reg >>> shift;
      acc_next = acc_reg + 48'(din) - est_full;
      if (est_full > 48'(adp_pkg::OFS_LIMIT)) begin
         est = adp_pkg::OFS_LIMIT;
      end else if (est_full < -48'(adp_pkg::OFS_LIMIT)) begin
         est = -adp_pkg::OFS_LIMIT;
      end else begin
         est = est_full[13:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg <= '0;
      end else if (!enable) begin
         acc_reg <= '0;
      end else if (sample_en && track) begin
         acc_reg <= acc_next;
      end
   end
endmodule

// ---- adp_core_chk.sv ----
// Purpose: port-level checks of the converter back end
// Assumes: one pclk domain; pins and sample clock arrive unsynchronised
// Notes: six stable pin cycles cover the input synchronisers
`timescale 1ns/1ps
module adp_core_chk #(
   parameter int WAKE_GLOBAL_CYC = adp_pkg::WAKE_GLOBAL_CYC
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sample_clk,
   input wire logic        power_ctrl_pin_1,
   input wire logic        power_ctrl_pin_2,
   input wire logic        power_ctrl_pin_3,
   input wire logic        bus_a_oe,
   input wire logic        bus_b_oe,
   input wire logic        output_clock_pos,
   input wire logic        output_clock_oe,
   input wire logic        data_valid_a,
   input wire logic        data_valid_b,
   input wire logic        low_power_mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic [2:0] pins = {power_ctrl_pin_1, power_ctrl_pin_2, power_ctrl_pin_3};
   logic [6:0]      gap_reg;
   // Low-time of the sample clock; saturates so it never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) gap_reg <= 7'h00;
      else if (sample_clk) gap_reg <= 7'h00;
      else if (gap_reg != 7'h7f) gap_reg <= gap_reg + 7'h01;
   end
   chk_ready_after_setup: assert property (psel && !penable |=> pready) // [APB]
      else $error("pready missing after setup");
   chk_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0) // [APB]
      else $error("error response malformed");
   chk_sleep_float: assert property ((pins == 3'b100) [*6] |=> !bus_a_oe && !bus_b_oe
      && !output_clock_oe && low_power_mode) else $error("outputs driven in sleep");
   chk_mux_a_float: assert property ((pins == 3'b111) [*6] |=> !bus_a_oe)
      else $error("bus A driven in mux mode");
   chk_cha_off_invalid: assert property ((pins == 3'b101) [*6] |=> !data_valid_a)
      else $error("channel A valid while off");
   chk_float_no_valid: assert property (!output_clock_oe [*3] |->
      !data_valid_a && !data_valid_b) else $error("valid data while floating");
   chk_slow_lowpwr: assert property (gap_reg >= 7'h46 |-> low_power_mode)
      else $error("no low power on stopped clock");
   chk_oclk_follows: assert property ($rose(sample_clk) && $past(presetn) |-> ##3
      (output_clock_pos || !output_clock_oe)) else $error("output clock late");
   cov_unmapped: cover property (pslverr);
   cov_mux: cover property (!bus_a_oe && bus_b_oe);
   cov_slow: cover property (low_power_mode && output_clock_oe);
endmodule
bind adp_core adp_core_chk #(.WAKE_GLOBAL_CYC(WAKE_GLOBAL_CYC)) u_chk (.*);

// ---- adp_far_model.sv ----
// Purpose: receiving logic that captures both buses on output clock rising edges and bus B on falling edges
// Assumes: sender registers clock and data on pclk
// Notes: capture lags each edge by two pclk to give the data margin
`timescale 1ns/1ps
module adp_far_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        output_clock_pos,
   input  wire logic [13:0] bus_a_data,
   input  wire logic [13:0] bus_b_data,
   output int               n_rise,
   output logic [13:0]      rise_a,
   output logic [13:0]      rise_b,
   output logic [13:0]      fall_b,
   output logic [13:0]      lvds_b
);
   logic [1:0] oq;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oq <= 2'h0;
         n_rise <= 0;
      end else begin
         oq <= {oq[0], output_clock_pos};
         if (oq == 2'b01) begin
            n_rise <= n_rise + 1;
            rise_a <= bus_a_data;
            rise_b <= bus_b_data;
         end
         if (oq == 2'b10) begin
            fall_b <= bus_b_data;
            for (int i = 0; i < 7; i++) lvds_b[2*i+1 -: 2] <= {bus_b_data[i], rise_b[i]};
         end
      end
   end
endmodule

// ---- test_adc_digital_post_processing.sv ----
// Purpose: self-checking bench for the converter back end
// Assumes: sample clock of 160 ns unrelated to pclk; APB answer in one access cycle
// Notes: global wake shortened to 20 cycles to keep the run short
`timescale 1ns/1ps
module test_adc_digital_post_processing;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q, q1;
   logic        pready, pslverr, e, sample_clk = 1'b0, sclk_run = 1'b1;
   logic [13:0] conv_a = 14'h0, conv_b = 14'h0, ex;
   logic [1:0]  conv_ovr_a = 2'h0, conv_ovr_b = 2'h0;
   logic        power_ctrl_pin_1 = 1'b0, power_ctrl_pin_2 = 1'b0, power_ctrl_pin_3 = 1'b0;
   logic        format_select_pin = 1'b0, serial_select_pin = 1'b0;
   logic [13:0] bus_a_data, bus_b_data, rise_a, rise_b, fall_b, lvds_b;
   logic        bus_a_oe, bus_b_oe, output_clock_pos, output_clock_oe;
   logic        data_valid_a, data_valid_b, low_power_mode;
   int          n_rise, num_errors = 0, n_compared = 0;
   adp_core #(.WAKE_GLOBAL_CYC(20)) dut (.*);
   adp_far_model far (.*);
   always #10 pclk = ~pclk;
   // Stops low when halted, as a real sample clock source would
   always #80 sample_clk = sclk_run ? ~sample_clk : 1'b0;
   task automatic results();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x) begin
         $display("ERROR %s expected %h seen %h", nm, x, g);
         num_errors++;
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
      if (pready !== 1'b1) chk("apb answer", 32'h1, 32'h0);
      if (pready !== 1'b1) results();
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, x, q);
   endtask
   task automatic samples(input int k);
      int t;
      int n;
      t = n_rise + k;
      n = 0;
      while (n_rise < t && n < 16 * k) begin
         @(posedge pclk);
         n++;
      end
      if (n_rise < t) chk("output clock running", 32'h1, 32'h0);
      if (n_rise < t) results();
   endtask
   task automatic lat(input logic [13:0] v, input int x);
      int t;
      samples(25);
      @(negedge sample_clk);
      @(posedge pclk);
      conv_a <= v;
      // Let the previous sample's capture land before counting
      repeat (3) @(posedge pclk);
      t = n_rise;
      while (rise_a !== v && n_rise < t + 40) samples(1);
      chk("latency", 32'(x), 32'(n_rise - t));
   endtask
   task automatic pins(input logic [2:0] v);
      {power_ctrl_pin_1, power_ctrl_pin_2, power_ctrl_pin_3} <= v;
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(adp_pkg::OFF_CTRL, 32'h4, "ctrl reset");
      rd(adp_pkg::OFF_GAIN, 32'h0, "gain reset");
      rd(adp_pkg::OFF_TC, 32'h0, "tc reset");
      rd(12'h100, 32'h0, "unmapped data");
      chk("unmapped error", 32'h1, 32'(e));
      conv_b <= 14'h0abc;
      apb(1'b1, adp_pkg::OFF_CTRL, 32'h24);
      lat(14'h0123, adp_pkg::RAW_LAT + 1);
      chk("bus B word", 32'h0abc, 32'(rise_b));
      apb(1'b1, adp_pkg::OFF_CTRL, 32'h25);
      lat(14'h0456, adp_pkg::RAW_LAT + adp_pkg::DIG_EXTRA + 1);
      for (int f = 0; f < 2; f++) begin
         apb(1'b1, adp_pkg::OFF_CTRL, 32'h24 | (32'(f) << 4));
         for (int o = 0; o < 3; o++) begin
            conv_ovr_a <= 2'(o);
            samples(25);
            ex = (o == 2) ? 14'h1fff : (o == 1) ? 14'h2000 : 14'h0456;
            if (f == 1) ex = ex ^ 14'h2000;
            chk("format clamp", 32'(ex), 32'(rise_a));
         end
      end
      conv_ovr_a <= 2'h0;
      conv_a <= 14'h1800;
      apb(1'b1, adp_pkg::OFF_CTRL, 32'h24);
      apb(1'b1, adp_pkg::OFF_GAIN, 32'hc);
      samples(25);
      chk("gain disabled", 32'h1800, 32'(rise_a));
      apb(1'b1, adp_pkg::OFF_CTRL, 32'h25);
      samples(25);
      chk("gain 6 dB", 32'h1fff, 32'(rise_a));
      apb(1'b1, adp_pkg::OFF_GAIN, 32'h0);
      conv_a <= 14'h1fff;
      apb(1'b1, adp_pkg::OFF_CTRL, 32'h27);
      samples(600);
      apb(1'b1, adp_pkg::OFF_CTRL, 32'h23);
      // About 600 samples of 1fff against a 1M-sample constant ramp it to 4, far from settled
      rd(adp_pkg::OFF_OFS_A, 32'h4, "estimate before hold");
      q1 = q;
      samples(100);
      rd(adp_pkg::OFF_OFS_A, q1, "held estimate");
      chk("estimate range", 32'h1, 32'(q1 > 0 && q1 <= 82));
      chk("corrected word", 32'(14'h1fff - q1[13:0]), 32'(rise_a));
      apb(1'b1, adp_pkg::OFF_CTRL, 32'h24);
      rd(adp_pkg::OFF_OFS_A, 32'h0, "estimate off");
      {conv_a, conv_b} <= {14'h0111, 14'h0222};
      pins(3'b111);
      samples(25);
      chk("mux A on rise", 32'h0111, 32'(rise_b));
      chk("mux B on fall", 32'h0222, 32'(fall_b));
      pins(3'b101);
      samples(25);
      chk("chan A off", 32'h0, 32'(data_valid_a));
      chk("chan B on", 32'h1, 32'(data_valid_b));
      apb(1'b1, adp_pkg::OFF_CTRL, 32'h124);
      repeat (4) @(posedge pclk);
      chk("chan B standby", 32'h0, 32'(data_valid_b));
      apb(1'b1, adp_pkg::OFF_CTRL, 32'h24);
      pins(3'b000);
      repeat (2000) @(posedge pclk);
      chk("chan A waking", 32'h0, 32'(data_valid_a));
      repeat (1000) @(posedge pclk);
      chk("chan A woken", 32'h1, 32'(data_valid_a));
      pins(3'b100);
      repeat (10) @(posedge pclk);
      chk("sleep bus B", 32'h0, 32'(bus_b_oe));
      pins(3'b000);
      // Sleep also reloads the standby timer, the longer of the two here
      repeat (2600) @(posedge pclk);
      chk("sleep woken", 32'h1, 32'(data_valid_b));
      apb(1'b1, adp_pkg::OFF_CTRL, 32'h2c);
      repeat (4) @(posedge pclk);
      chk("sleep bit bus A", 32'h0, 32'(bus_a_oe));
      conv_b <= 14'h2a5c;
      apb(1'b1, adp_pkg::OFF_CTRL, 32'h4);
      // Words stay zero until both wake timers have run out
      samples(350);
      chk("lvds word", 32'h2a5c, 32'(lvds_b));
      {format_select_pin, serial_select_pin} <= 2'b11;
      apb(1'b1, adp_pkg::OFF_CTRL, 32'h44);
      samples(25);
      chk("pin format cmos", 32'h0a5c, 32'(rise_b));
      sclk_run <= 1'b0;
      repeat (100) @(posedge pclk);
      chk("slow clock", 32'h1, 32'(low_power_mode));
      sclk_run <= 1'b1;
      apb(1'b1, adp_pkg::OFF_GAIN, 32'h5);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(adp_pkg::OFF_GAIN, 32'h0, "gain after reset");
      rd(adp_pkg::OFF_CTRL, 32'h4, "ctrl after reset");
      results();
   end
endmodule
